// ---- rtl/pie_pkg.sv ----
/*
 * Constants for the port one ingress/egress control block: register map,
 * field positions, reset values and bus states.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package pie_pkg;
    // ****************************************************
    // Register map (byte addresses)
    // ****************************************************
    localparam logic [7:0] PIE_ADR_CTRL = 8'h6c;   // Port one ingress/egress control
    localparam logic [7:0] PIE_ADR_DTAG = 8'h70;   // Port default tag
    localparam logic [7:0] PIE_ADR_STAT = 8'h74;   // Last ingress decision, read only
    localparam int PIE_ADR_W = 8;                  // Address width
    localparam int PIE_DAT_W = 32;                 // Data width

    // ****************************************************
    // Control field positions
    // ****************************************************
    localparam int PIE_F_LAMP_HI = 14;    // Lamp override top
    localparam int PIE_F_LAMP_EN = 14;    // Lamp override enable
    localparam int PIE_F_LAMP_ONE = 13;   // Lamp one level
    localparam int PIE_F_LAMP_ZERO = 12;  // Lamp zero level
    localparam int PIE_F_FLT2 = 11;       // Filter against second address
    localparam int PIE_F_FLT1 = 10;       // Filter against first address
    localparam int PIE_F_DROPTAG = 9;     // Drop tagged ingress
    localparam int PIE_F_TWOQ = 8;        // Two output queues
    localparam int PIE_F_STORM = 7;       // Broadcast storm protection
    localparam int PIE_F_DSCP = 6;        // DiffServ classification
    localparam int PIE_F_P8021 = 5;       // 802.1p classification
    localparam int PIE_F_PRIO_HI = 4;     // Port default priority top
    localparam int PIE_F_PRIO_LO = 3;     // Port default priority bottom
    localparam int PIE_F_INSERT = 2;      // Tag insertion
    localparam int PIE_F_REMOVE = 1;      // Tag removal
    localparam int PIE_F_FOURQ = 0;       // Four output queues

    // ****************************************************
    // Reset values and masks
    // ****************************************************
    localparam logic [15:0] PIE_CTRL_RST = 16'h0000;   // Control resets to zero
    localparam logic [15:0] PIE_CTRL_MASK = 16'h7fff;  // Bit 15 reserved, reads zero
    localparam logic [15:0] PIE_DTAG_RST = 16'h0001;   // Default VID one, CFI and priority zero

    // ****************************************************
    // Queue modes
    // ****************************************************
    localparam logic [1:0] PIE_QM_SINGLE = 2'h0;  // One queue
    localparam logic [1:0] PIE_QM_TWO = 2'h1;     // Two queues
    localparam logic [1:0] PIE_QM_FOUR = 2'h2;    // Four queues

    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        PIE_ST_IDLE = 2'b01,
        PIE_ST_ACK = 2'b10
    } pie_bus_st_t;
endpackage

// ---- rtl/pie_port_ctrl.sv ----
/*
 * Port one ingress/egress control register and the per-frame decisions it
 * steers: lamp override, source filtering, tagged drop, storm protection,
 * priority classification, queue split and egress tag edits.
 * Assumes frame descriptors arrive synchronous to sys_clk as one-cycle
 * strobes and that the Wishbone master follows classic single cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module pie_port_ctrl (
    input wire logic sys_clk,                            // System clock, 100 MHz
    input wire logic rstn,                               // Asynchronous reset, active low
    input wire logic wb_cyc_i,                           // Bus cycle
    input wire logic wb_stb_i,                           // Bus strobe
    input wire logic wb_we_i,                            // Write enable
    input wire logic [pie_pkg::PIE_ADR_W-1:0] wb_adr_i,  // Byte address
    input wire logic [3:0] wb_sel_i,                     // Byte lane selects
    input wire logic [pie_pkg::PIE_DAT_W-1:0] wb_dat_i,  // Write data
    output logic [pie_pkg::PIE_DAT_W-1:0] wb_dat_o,      // Read data
    output logic wb_ack_o,                               // Acknowledge
    input wire logic lamp_normal_zero,                   // Normal lamp zero level
    input wire logic lamp_normal_one,                    // Normal lamp one level
    output logic port_lamp_zero,                         // Lamp zero pin
    output logic port_lamp_one,                          // Lamp one pin
    input wire logic rx_valid,                           // Ingress frame strobe
    input wire logic rx_tagged,                          // Ingress frame carries a tag
    input wire logic rx_sa_first,                        // Source matches first filter address
    input wire logic rx_sa_second,                       // Source matches second filter address
    input wire logic rx_storm,                           // Storm limiter says over limit
    input wire logic rx_dscp_ok,                         // DiffServ mapping found
    input wire logic [1:0] rx_dscp_prio,                 // DiffServ priority
    input wire logic rx_tag_ok,                          // Tag priority mapping found
    input wire logic [1:0] rx_tag_prio,                  // Tag priority
    output logic dec_valid,                              // Decision strobe
    output logic dec_drop,                               // Drop this frame
    output logic [1:0] dec_prio,                         // Priority class
    output logic [1:0] dec_queue,                        // Output queue index
    output logic [1:0] queue_mode,                       // Output queue split
    output logic [15:0] own_default_tag,                 // This port's default tag
    input wire logic tx_valid,                           // Egress frame strobe
    input wire logic tx_rx_tagged,                       // Frame was tagged when received
    input wire logic [15:0] tx_ingress_tag,              // Default tag of the receiving port
    output logic eg_valid,                               // Egress edit strobe
    output logic eg_insert,                              // Insert a tag
    output logic eg_strip,                               // Strip the tag
    output logic [15:0] eg_tag                           // Tag to insert
);
    import pie_pkg::*;

    // ****************************************************
    // State
    // ****************************************************
    pie_bus_st_t bus_reg, bus_next;                 // Bus handshake state
    logic [15:0] ctrl_reg, ctrl_next;               // Control register
    logic [15:0] dtag_reg, dtag_next;               // Default tag register
    logic [31:0] rdat_reg, rdat_next;               // Read data
    logic lamp0_reg, lamp0_next;                    // Lamp zero
    logic lamp1_reg, lamp1_next;                    // Lamp one
    logic dv_reg, dv_next;                          // Decision strobe
    logic drop_reg, drop_next;                      // Drop flag
    logic [1:0] prio_reg, prio_next;                // Priority
    logic [1:0] q_reg, q_next;                      // Queue index
    logic [1:0] qm_reg, qm_next;                    // Queue mode
    logic ev_reg, ev_next;                          // Egress strobe
    logic ins_reg, ins_next;                        // Insert flag
    logic strip_reg, strip_next;                    // Strip flag
    logic [15:0] etag_reg, etag_next;               // Egress tag
    logic req;                                      // New bus request
    logic [3:0] stat_word;                          // Status fields

    assign req = wb_cyc_i && wb_stb_i && (bus_reg == PIE_ST_IDLE);
    assign stat_word = {drop_reg, dv_reg, prio_reg};

    // ****************************************************
    // Wishbone slave
    // ****************************************************
    // One wait state: ack comes at the edge after the request is seen,
    // then drops for a cycle so a held strobe is not taken twice.
    always_comb begin
        bus_next = bus_reg;
        ctrl_next = ctrl_reg;
        dtag_next = dtag_reg;
        rdat_next = rdat_reg;
        case (bus_reg)
            PIE_ST_IDLE: begin
                if (req) begin
                    bus_next = PIE_ST_ACK;
                    rdat_next = 32'h0000_0000;   // Unmapped addresses read zero
                    case (wb_adr_i)
                        PIE_ADR_CTRL: begin
                            rdat_next = {16'h0000, ctrl_reg};
                            if (wb_we_i) begin
                                // Reserved bit 15 stays zero
                                if (wb_sel_i[0]) ctrl_next[7:0] = wb_dat_i[7:0];
                                if (wb_sel_i[1]) ctrl_next[15:8] = wb_dat_i[15:8] & PIE_CTRL_MASK[15:8];
                            end
                        end
                        PIE_ADR_DTAG: begin
                            rdat_next = {16'h0000, dtag_reg};
                            if (wb_we_i) begin
                                if (wb_sel_i[0]) dtag_next[7:0] = wb_dat_i[7:0];
                                if (wb_sel_i[1]) dtag_next[15:8] = wb_dat_i[15:8];
                            end
                        end
                        PIE_ADR_STAT: begin
                            rdat_next = {28'h0000000, stat_word};
                        end
                        default: begin
                            rdat_next = 32'h0000_0000;   // Writes ignored
                        end
                    endcase
                end
            end
            PIE_ST_ACK: begin
                bus_next = PIE_ST_IDLE;
            end
            default: begin
                bus_next = PIE_ST_IDLE;
            end
        endcase
    end

    // Bus registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bus_reg <= PIE_ST_IDLE;
            ctrl_reg <= PIE_CTRL_RST;
            dtag_reg <= PIE_DTAG_RST;
            rdat_reg <= 32'h0000_0000;
        end else begin
            bus_reg <= bus_next;
            ctrl_reg <= ctrl_next;
            dtag_reg <= dtag_next;
            rdat_reg <= rdat_next;
        end
    end

    // ****************************************************
    // Port decisions
    // ****************************************************
    // Everything is registered so each output comes from a flop; the cost
    // is one cycle between a descriptor strobe and its decision.
    always_comb begin
        // Lamp override; top bit clear passes the normal lamp function
        if (ctrl_reg[PIE_F_LAMP_EN]) begin
            lamp0_next = ctrl_reg[PIE_F_LAMP_ZERO];
            lamp1_next = ctrl_reg[PIE_F_LAMP_ONE];
        end else begin
            lamp0_next = lamp_normal_zero;
            lamp1_next = lamp_normal_one;
        end
        // Queue split; four-queue wins when both bits are set
        if (ctrl_reg[PIE_F_FOURQ]) begin
            qm_next = PIE_QM_FOUR;
        end else if (ctrl_reg[PIE_F_TWOQ]) begin
            qm_next = PIE_QM_TWO;
        end else begin
            qm_next = PIE_QM_SINGLE;
        end
        // Ingress decision
        dv_next = rx_valid;
        drop_next = drop_reg;
        prio_next = prio_reg;
        q_next = q_reg;
        if (rx_valid) begin
            drop_next = (ctrl_reg[PIE_F_FLT2] && rx_sa_second)
                || (ctrl_reg[PIE_F_FLT1] && rx_sa_first)
                || (ctrl_reg[PIE_F_DROPTAG] && rx_tagged)
                || (ctrl_reg[PIE_F_STORM] && rx_storm);
            if ((ctrl_reg[PIE_F_DSCP] && rx_dscp_ok) || (ctrl_reg[PIE_F_P8021] && rx_tag_ok)) begin
                // Combined result of the enabled classifiers
                prio_next = ((ctrl_reg[PIE_F_DSCP] && rx_dscp_ok) ? rx_dscp_prio : 2'h0)
                    | ((ctrl_reg[PIE_F_P8021] && rx_tag_ok) ? rx_tag_prio : 2'h0);
            end else begin
                prio_next = ctrl_reg[PIE_F_PRIO_HI:PIE_F_PRIO_LO];
            end
            // Class still computed in single mode, but queue stays zero
            case (qm_next)
                PIE_QM_FOUR: q_next = prio_next;
                PIE_QM_TWO: q_next = {1'b0, prio_next[1]};
                default: q_next = 2'h0;
            endcase
        end
        // Egress edits
        ev_next = tx_valid;
        ins_next = ins_reg;
        strip_next = strip_reg;
        etag_next = etag_reg;
        if (tx_valid) begin
            ins_next = ctrl_reg[PIE_F_INSERT] && !tx_rx_tagged;
            strip_next = ctrl_reg[PIE_F_REMOVE] && tx_rx_tagged;
            etag_next = tx_ingress_tag;
        end
    end

    // Decision registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lamp0_reg <= 1'b0;
            lamp1_reg <= 1'b0;
            qm_reg <= PIE_QM_SINGLE;
            dv_reg <= 1'b0;
            drop_reg <= 1'b0;
            prio_reg <= 2'h0;
            q_reg <= 2'h0;
            ev_reg <= 1'b0;
            ins_reg <= 1'b0;
            strip_reg <= 1'b0;
            etag_reg <= 16'h0000;
        end else begin
            lamp0_reg <= lamp0_next;
            lamp1_reg <= lamp1_next;
            qm_reg <= qm_next;
            dv_reg <= dv_next;
            drop_reg <= drop_next;
            prio_reg <= prio_next;
            q_reg <= q_next;
            ev_reg <= ev_next;
            ins_reg <= ins_next;
            strip_reg <= strip_next;
            etag_reg <= etag_next;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign wb_dat_o = rdat_reg;
    assign wb_ack_o = (bus_reg == PIE_ST_ACK);
    assign port_lamp_zero = lamp0_reg;
    assign port_lamp_one = lamp1_reg;
    assign dec_valid = dv_reg;
    assign dec_drop = drop_reg;
    assign dec_prio = prio_reg;
    assign dec_queue = q_reg;
    assign queue_mode = qm_reg;
    assign own_default_tag = dtag_reg;
    assign eg_valid = ev_reg;
    assign eg_insert = ins_reg;
    assign eg_strip = strip_reg;
    assign eg_tag = etag_reg;

    // ****************************************************
    // Assertions
    // ****************************************************
    // Lamp pins follow the override when its top bit is set and the normal
    // lamp levels otherwise, one cycle behind the control register
    a_lamp_override: assert property (@(posedge sys_clk) disable iff (!rstn)
        ctrl_reg[PIE_F_LAMP_EN] |=> (port_lamp_one == $past(ctrl_reg[PIE_F_LAMP_ONE]))
            && (port_lamp_zero == $past(ctrl_reg[PIE_F_LAMP_ZERO])))
        else $error("lamp override not applied");
    a_lamp_normal: assert property (@(posedge sys_clk) disable iff (!rstn)
        !ctrl_reg[PIE_F_LAMP_EN] |=> (port_lamp_one == $past(lamp_normal_one))
            && (port_lamp_zero == $past(lamp_normal_zero)))
        else $error("normal lamp levels not passed");
    // Each drop cause on its own must drop the frame
    a_filter_second: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && ctrl_reg[PIE_F_FLT2] && rx_sa_second |=> dec_valid && dec_drop)
        else $error("second address not filtered");
    a_filter_first: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && ctrl_reg[PIE_F_FLT1] && rx_sa_first |=> dec_valid && dec_drop)
        else $error("first address not filtered");
    a_drop_tagged: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && ctrl_reg[PIE_F_DROPTAG] && rx_tagged |=> dec_drop)
        else $error("tagged frame not dropped");
    a_storm_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && ctrl_reg[PIE_F_STORM] && rx_storm |=> dec_drop)
        else $error("storm frame not dropped");
    // A frame that trips no cause is never dropped, whatever the enables
    a_no_cause_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && !rx_tagged && !rx_sa_first && !rx_sa_second && !rx_storm |=> !dec_drop)
        else $error("frame dropped without cause");
    // Priority: default field, each classifier alone, then both ORed
    a_default_prio: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && !ctrl_reg[PIE_F_DSCP] && !ctrl_reg[PIE_F_P8021]
            |=> dec_prio == $past(ctrl_reg[PIE_F_PRIO_HI:PIE_F_PRIO_LO]))
        else $error("port default priority not used");
    a_dscp_only: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && ctrl_reg[PIE_F_DSCP] && !ctrl_reg[PIE_F_P8021] && rx_dscp_ok
            |=> dec_prio == $past(rx_dscp_prio))
        else $error("code point priority not used");
    a_tag_prio_only: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && !ctrl_reg[PIE_F_DSCP] && ctrl_reg[PIE_F_P8021] && rx_tag_ok
            |=> dec_prio == $past(rx_tag_prio))
        else $error("tag priority not used");
    a_prio_or: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_valid && ctrl_reg[PIE_F_DSCP] && ctrl_reg[PIE_F_P8021] && rx_dscp_ok && rx_tag_ok
            |=> dec_prio == ($past(rx_dscp_prio) | $past(rx_tag_prio)))
        else $error("classifier results not combined");
    // Queue index against the mode latched together with the decision
    a_single_queue: assert property (@(posedge sys_clk) disable iff (!rstn)
        dec_valid && queue_mode == PIE_QM_SINGLE |-> dec_queue == 2'h0)
        else $error("single mode used a queue other than zero");
    a_two_queue: assert property (@(posedge sys_clk) disable iff (!rstn)
        dec_valid && queue_mode == PIE_QM_TWO |-> dec_queue == {1'b0, dec_prio[1]})
        else $error("two-queue index wrong");
    a_four_queue: assert property (@(posedge sys_clk) disable iff (!rstn)
        dec_valid && queue_mode == PIE_QM_FOUR |-> dec_queue == dec_prio)
        else $error("four-queue index wrong");
    a_four_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
        ctrl_reg[PIE_F_FOURQ] |=> queue_mode == PIE_QM_FOUR)
        else $error("four-queue mode not selected");
    // Egress edits take the receiving port's tag, never this port's own
    a_insert_tag: assert property (@(posedge sys_clk) disable iff (!rstn)
        tx_valid |=> eg_valid && (eg_insert == ($past(ctrl_reg[PIE_F_INSERT]) && !$past(tx_rx_tagged)))
            && (eg_tag == $past(tx_ingress_tag)))
        else $error("egress insert or tag wrong");
    a_strip_tag: assert property (@(posedge sys_clk) disable iff (!rstn)
        tx_valid |=> eg_strip == ($past(ctrl_reg[PIE_F_REMOVE]) && $past(tx_rx_tagged)))
        else $error("egress strip wrong");
    // Write taken, ack, one idle cycle, then a read of the same register
    // taken: the read data shows the written bits with bit 15 cleared
    a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
        req && wb_we_i && wb_adr_i == PIE_ADR_CTRL && wb_sel_i[1:0] == 2'h3
            ##3 req && !wb_we_i && wb_adr_i == PIE_ADR_CTRL
            |=> wb_dat_o[15:0] == ($past(wb_dat_i[15:0], 4) & PIE_CTRL_MASK))
        else $error("control readback differs");
    a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_write_ctrl: cover property (@(posedge sys_clk) disable iff (!rstn)
        wb_ack_o && wb_we_i && wb_adr_i == PIE_ADR_CTRL);
    c_drop_frame: cover property (@(posedge sys_clk) disable iff (!rstn) dec_valid && dec_drop);
    c_four_queue: cover property (@(posedge sys_clk) disable iff (!rstn)
        dec_valid && queue_mode == PIE_QM_FOUR && dec_queue == 2'h3);
    c_insert: cover property (@(posedge sys_clk) disable iff (!rstn) eg_valid && eg_insert);
endmodule

`default_nettype wire

// ---- dv/test_pie_port_ctrl.sv ----
/*
 * Self-checking bench for the port one control block: register readback,
 * lamp override, ingress decisions, queue split and egress tag edits.
 * Assumes pie_pkg, one 100 MHz clock and a classic Wishbone slave.
 */
`timescale 1ns/1ns
`default_nettype none
module test_pie_port_ctrl;
    import pie_pkg::*;
    // ****************************************************
    // Signals, counters and the design
    // ****************************************************
    logic sys_clk = 1'b0; // 100 MHz clock
    logic rstn = 1'b0; // Reset, active low
    logic cyc = 1'b0; // Bus cycle
    logic stb = 1'b0; // Bus strobe
    logic we = 1'b0; // Bus write
    logic [7:0] adr = 8'h00; // Bus address
    logic [31:0] wdat = 32'h0; // Bus write data
    logic [3:0] bsel = 4'hf; // Bus byte lanes
    logic [31:0] rdat; // Bus read data
    logic ack; // Bus acknowledge
    logic ln0 = 1'b0, ln1 = 1'b0, lz, lo; // Lamp inputs and pins
    logic rxv = 1'b0, txv = 1'b0; // Frame strobes
    logic [31:0] v = 32'h0; // Packed frame fields
    logic dv, dd, ev, ei, es; // Decision outputs
    logic [1:0] dp, dq, qm; // Priority, queue, queue mode
    logic [15:0] odt, etag; // Default tag, egress tag
    int n_mismatch = 0; // Failed compares
    int n_checks = 0; // All compares
    int seed = 26; // Fixed seed keeps runs repeatable
    logic [15:0] c; // Control value under test
    logic [31:0] r; // Read result
    pie_port_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .lamp_normal_zero(ln0), .lamp_normal_one(ln1), .port_lamp_zero(lz), .port_lamp_one(lo),
        .rx_valid(rxv), .rx_tagged(v[0]), .rx_sa_first(v[1]), .rx_sa_second(v[2]), .rx_storm(v[3]),
        .rx_dscp_ok(v[4]), .rx_dscp_prio(v[6:5]), .rx_tag_ok(v[7]), .rx_tag_prio(v[9:8]),
        .dec_valid(dv), .dec_drop(dd), .dec_prio(dp), .dec_queue(dq), .queue_mode(qm),
        .own_default_tag(odt), .tx_valid(txv), .tx_rx_tagged(v[10]), .tx_ingress_tag(v[31:16]),
        .eg_valid(ev), .eg_insert(ei), .eg_strip(es), .eg_tag(etag));
    // Free-running clock, 10 ns period
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ****************************************************
    // Tasks and expectation functions
    // ****************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // One classic cycle; waits for ack, never assumes its latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        check(32'(ack), 32'h1, "bus answer");
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Enabled classifiers OR together; default field only when none hits
    function automatic logic [1:0] exp_prio(input logic [15:0] k, input logic [31:0] f);
        logic d, t;
        d = k[PIE_F_DSCP] & f[4];
        t = k[PIE_F_P8021] & f[7];
        if (d | t) begin
            return (d ? f[6:5] : 2'h0) | (t ? f[9:8] : 2'h0);
        end
        return k[4:3];
    endfunction
    function automatic logic [1:0] exp_qm(input logic [15:0] k);
        return k[PIE_F_FOURQ] ? PIE_QM_FOUR : (k[PIE_F_TWOQ] ? PIE_QM_TWO : PIE_QM_SINGLE);
    endfunction
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        logic [15:0] corner [6] = '{16'hffff, 16'h0000, 16'h4101, 16'h5860, 16'h6694, 16'h0100};
        logic [1:0] p;
        logic x; // Expected drop
        logic [31:0] e; // Expected queue index
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        wb(1'b0, PIE_ADR_CTRL, 32'h0, r);
        check(r, 32'h0, "ctrl reset");
        wb(1'b0, PIE_ADR_DTAG, 32'h0, r);
        check(r, 32'h1, "default tag reset");
        check(32'(odt), 32'h1, "default tag port");
        wb(1'b1, 8'h80, 32'hffff, r);
        wb(1'b0, 8'h80, 32'h0, r);
        check(r, 32'h0, "unmapped read");
        c = 16'($random(seed));
        wb(1'b1, PIE_ADR_DTAG, {16'h0, c}, r);
        wb(1'b0, PIE_ADR_DTAG, 32'h0, r);
        check(r, {16'h0, c}, "default tag readback");
        check(32'(odt), {16'h0, c}, "default tag port value");
        // Lane zero alone must leave the upper control byte untouched
        wb(1'b1, PIE_ADR_CTRL, 32'h0, r);
        bsel <= 4'h1;
        wb(1'b1, PIE_ADR_CTRL, 32'hffff, r);
        bsel <= 4'hf;
        wb(1'b0, PIE_ADR_CTRL, 32'h0, r);
        check(r, 32'h00ff, "ctrl lane write");
        $display("test registers done");
        for (int i = 0; i < 60; i++) begin
            c = (i < 6) ? corner[i] : 16'($random(seed));
            wb(1'b1, PIE_ADR_CTRL, {16'h0, c}, r);
            wb(1'b0, PIE_ADR_CTRL, 32'h0, r);
            check(r, {17'h0, c[14:0]}, "ctrl readback");
            // Ingress and egress frames in the same cycle, fields at random
            @(posedge sys_clk);
            v <= $random(seed);
            rxv <= 1'b1;
            txv <= 1'b1;
            ln0 <= 1'($random(seed));
            ln1 <= 1'($random(seed));
            @(posedge sys_clk);
            rxv <= 1'b0;
            txv <= 1'b0;
            #1;
            p = exp_prio(c, v);
            x = (c[11] & v[2]) | (c[10] & v[1]) | (c[9] & v[0]) | (c[7] & v[3]);
            e = (exp_qm(c) == PIE_QM_FOUR) ? 32'(p) : (exp_qm(c) == PIE_QM_TWO) ? 32'(p[1]) : 32'h0;
            check(32'({dv, ev}), 32'h3, "strobes");
            check(32'(dd), 32'(x), "drop");
            check(32'(dp), 32'(p), "priority");
            check(32'(qm), 32'(exp_qm(c)), "queue mode");
            check(32'(dq), e, "queue");
            check(32'({ei, es}), 32'({c[2] & ~v[10], c[1] & v[10]}), "tag edit");
            check(32'(etag), 32'(v[31:16]), "inserted tag");
            check(32'({lo, lz}), 32'(c[14] ? c[13:12] : {ln1, ln0}), "lamps");
            @(posedge sys_clk);
            #1;
            check(32'({dv, ev}), 32'h0, "strobe width");
            // Status holds the last drop and priority; the strobe is long gone
            wb(1'b0, PIE_ADR_STAT, 32'h0, r);
            check(r, 32'({x, 1'b0, p}), "status");
        end
        $display("test frames done");
        close_out();
    end
    // Whole run needs well under 5,000 cycles
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
